// file: hw/acsp_consts.svh
/*
  Constants of the ADC configuration serial port: instruction layout, byte counts,
  transfer register address and value.
  Assumes inclusion by the port module only.
*/
`ifndef ACSP_CONSTS_SVH
`define ACSP_CONSTS_SVH
`define ACSP_INSTR_BITS    5'd16
`define ACSP_ADDR_W        13
`define ACSP_RW_BIT        15
`define ACSP_CNT_HI_BIT    14
`define ACSP_CNT_LO_BIT    13
`define ACSP_CNT_STREAM    2'b11
`define ACSP_XFER_ADDR     13'h00_FF
`define ACSP_XFER_GO       8'h01
`define ACSP_CFG_ADDR      13'h00_00
`define ACSP_LSB_FIRST_BIT 6
`endif

// file: hw/acsp_edge.sv
/*
  Two-flop synchroniser for one pin with rise and fall detection.
  Assumes the pin is asynchronous to mclk_i.
*/
module acsp_edge (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      lvl_o,
  output logic      rise_o,
  output logic      fall_o
);
  logic s1_q, s2_q, s3_q;
  logic s1_d, s2_d, s3_d;
  always_comb begin
    s1_d = pin_i;
    s2_d = s1_q;
    s3_d = s2_q;
  end
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end
  assign lvl_o  = s2_q;
  assign rise_o = s2_q & ~s3_q;
  assign fall_o = ~s2_q & s3_q;
endmodule // acsp_edge

// file: hw/acsp_pkg.sv
/*
  Types of the ADC configuration serial port.
  Assumes the constants header sits beside it.
*/
package acsp_pkg;
  typedef enum logic [1:0] {
    ACSP_IDLE  = 2'b00,
    ACSP_INSTR = 2'b01,
    ACSP_DATA  = 2'b10
  } acsp_state_t;
endpackage

// file: hw/acsp_port.sv
/*
  Configuration serial port slave: decodes 16-bit instructions from the serial link,
  writes or reads a register space through a simple register-side port.
  Assumes the register space answers reads combinationally from reg_addr_o, and that
  the serial clock is far slower than mclk_i (several mclk cycles per half period).
*/
`include "acsp_consts.svh"
// Functional notes
// - decode only while select is low
// - frame starts at first rise after select falls
// - 16-bit instruction then data bytes
// - select high between bytes stalls, resumes
// - count 11 streams until select rises
// - select rise mid-byte resets state machine
// - select high at reset selects pin straps
// - select tied low gives 2-wire mode
// - streaming without select never ends
// - instruction bit chooses read or write
// - readback turns data pin to output
// - msb first, lsb first by config bit for data bytes; instruction always msb first
// - sample data on rising serial clock
// - drive readback data after falling edge
// - release data pin after rising edge
// - writes apply after transfer register 0x01
module acsp_port
  import acsp_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        sclk_i,
  input  wire logic        select_low_n_i,
  input  wire logic        sdio_i,
  output logic             sdio_o,
  output logic             sdio_oe_o,
  input  wire logic [7:0]  reg_rdata_i,
  output logic [12:0]      reg_addr_o,
  output logic [7:0]       reg_wdata_o,
  output logic             reg_wr_o,
  output logic             reg_apply_o,
  output logic             lsb_first_o,
  output logic             strap_mode_o,
  output logic             test_pattern_strap_o,
  output logic             reduced_swing_strap_o
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic sclk_s, sclk_rise, sclk_fall;
  logic sel_s, sel_rise, sel_fall;
  logic din_s;

  acsp_edge u_sclk (.mclk_i(mclk_i), .rst_i(rst_i), .pin_i(sclk_i),
                    .lvl_o(sclk_s), .rise_o(sclk_rise), .fall_o(sclk_fall));
  acsp_edge u_sel  (.mclk_i(mclk_i), .rst_i(rst_i), .pin_i(select_low_n_i),
                    .lvl_o(sel_s), .rise_o(sel_rise), .fall_o(sel_fall));
  acsp_edge u_din  (.mclk_i(mclk_i), .rst_i(rst_i), .pin_i(sdio_i),
                    .lvl_o(din_s), .rise_o(), .fall_o());

  // ----------------------------------------
  // state
  // ----------------------------------------
  acsp_state_t st_q, st_d;
  logic [15:0] sh_q, sh_d;
  logic [4:0]  cnt_q, cnt_d;
  logic        rd_q, rd_d;
  logic [1:0]  bytes_q, bytes_d;
  logic [12:0] addr_q, addr_d;
  logic [7:0]  tx_q, tx_d;
  logic        oe_q, oe_d, dout_q, dout_d;
  logic        wr_q, wr_d, apply_q, apply_d;
  logic [7:0]  wdata_q, wdata_d;
  logic        lsb_q, lsb_d;
  logic        strap_q, strap_d, tp_q, tp_d, rs_q, rs_d;
  // counts the edges after release until the pin synchronisers hold real levels
  logic [1:0]  seen_q, seen_d;

  // next shift value honouring bit order
  function automatic logic [7:0] ins_bit(input logic [7:0] v, input logic b,
                                         input logic lsb);
    ins_bit = lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  logic [7:0] rx_byte;
  logic [7:0] rd_byte;
  assign rx_byte = ins_bit(sh_q[7:0], din_s, lsb_q);
  assign rd_byte = reg_rdata_i;

  always_comb begin
    st_d = st_q; sh_d = sh_q; cnt_d = cnt_q; rd_d = rd_q; bytes_d = bytes_q;
    addr_d = addr_q; tx_d = tx_q; oe_d = oe_q; dout_d = dout_q;
    wr_d = 1'b0; apply_d = 1'b0; wdata_d = wdata_q; lsb_d = lsb_q;
    strap_d = strap_q; tp_d = tp_q; rs_d = rs_q; seen_d = seen_q;
    if (seen_q != 2'b11)
      seen_d = seen_q + 2'b01;
    // synchroniser flops were reset too, so the pins are only valid two edges on
    if (seen_q == 2'b10 && sel_s) begin
      strap_d = 1'b1;
      tp_d    = sclk_s;
      rs_d    = din_s;
    end
    if (sel_rise) begin
      if (cnt_q != 5'd0)
        st_d = ACSP_IDLE;
      // stall otherwise keeps state, resumes on select low; streaming ends here
      if (st_q == ACSP_DATA && bytes_q == `ACSP_CNT_STREAM)
        st_d = ACSP_IDLE;
      if (st_d == ACSP_IDLE) begin
        cnt_d = 5'd0;
        oe_d  = 1'b0;
      end
    end
    if (sel_fall && st_q == ACSP_IDLE && !strap_q) begin
      st_d = ACSP_INSTR; cnt_d = 5'd0;
    end
    if (!sel_s && !strap_q) begin
      if (st_q == ACSP_IDLE && seen_q == 2'b11) begin
        st_d = ACSP_INSTR; cnt_d = 5'd0;
      end
      if (sclk_rise && st_q == ACSP_INSTR) begin
        sh_d  = {sh_q[14:0], din_s};
        cnt_d = cnt_q + 5'd1;
        if (cnt_q == `ACSP_INSTR_BITS - 5'd1) begin
          rd_d    = sh_d[`ACSP_RW_BIT];
          bytes_d = {sh_d[`ACSP_CNT_HI_BIT], sh_d[`ACSP_CNT_LO_BIT]};
          addr_d  = sh_d[12:0];
          cnt_d   = 5'd0;
          st_d    = ACSP_DATA;
        end
      end else if (st_q == ACSP_DATA) begin
        if (rd_q && sclk_fall) begin
          if (cnt_q == 5'd0) tx_d = rd_byte;
          oe_d   = 1'b1;
          dout_d = lsb_q ? ((cnt_q == 5'd0) ? rd_byte[0] : tx_q[cnt_q[2:0]])
                         : ((cnt_q == 5'd0) ? rd_byte[7] : tx_q[3'd7 - cnt_q[2:0]]);
        end
        if (sclk_rise) begin
          sh_d[7:0] = rx_byte;
          cnt_d = cnt_q + 5'd1;
          if (cnt_q == 5'd7) begin
            cnt_d = 5'd0;
            if (!rd_q) begin
              wr_d    = 1'b1;
              wdata_d = rx_byte;
              if (addr_q == `ACSP_XFER_ADDR && rx_byte == `ACSP_XFER_GO)
                apply_d = 1'b1;
              if (addr_q == `ACSP_CFG_ADDR)
                lsb_d = rx_byte[`ACSP_LSB_FIRST_BIT];
            end
            addr_d = addr_q + 13'h0_001;
            if (bytes_q != `ACSP_CNT_STREAM) begin
              bytes_d = bytes_q - 2'b01;
              if (bytes_q == 2'b00) begin
                st_d = ACSP_IDLE;
                // controller has taken the last bit at this rise, hand the line back
                if (rd_q) oe_d = 1'b0;
              end
            end
          end
        end
      end
    end
    if (sel_s && st_d == ACSP_IDLE) begin
      oe_d = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_q <= ACSP_IDLE; sh_q <= 16'h0000; cnt_q <= 5'd0; rd_q <= 1'b0;
      bytes_q <= 2'b00; addr_q <= 13'h0000; tx_q <= 8'h00; oe_q <= 1'b0;
      dout_q <= 1'b0; wr_q <= 1'b0; apply_q <= 1'b0; wdata_q <= 8'h00;
      lsb_q <= 1'b0; strap_q <= 1'b0; tp_q <= 1'b0;
      rs_q <= 1'b0; seen_q <= 2'b00;
    end else begin
      st_q <= st_d; sh_q <= sh_d; cnt_q <= cnt_d; rd_q <= rd_d;
      bytes_q <= bytes_d; addr_q <= addr_d; tx_q <= tx_d; oe_q <= oe_d;
      dout_q <= dout_d; wr_q <= wr_d; apply_q <= apply_d; wdata_q <= wdata_d;
      lsb_q <= lsb_d; strap_q <= strap_d; tp_q <= tp_d;
      rs_q <= rs_d; seen_q <= seen_d;
    end
  end

  // addr pointer is a register; reads see the current byte address
  assign reg_addr_o            = addr_q;
  assign reg_wdata_o           = wdata_q;
  assign reg_wr_o              = wr_q;
  assign reg_apply_o           = apply_q;
  assign lsb_first_o           = lsb_q;
  assign sdio_o                = dout_q;
  assign sdio_oe_o             = oe_q;
  assign strap_mode_o          = strap_q;
  assign test_pattern_strap_o  = tp_q;
  assign reduced_swing_strap_o = rs_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_apply_only_xfer;
    @(posedge mclk_i) disable iff (rst_i)
      reg_apply_o |-> reg_wr_o && reg_addr_o == (`ACSP_XFER_ADDR + 13'h0_001)
                      && reg_wdata_o == `ACSP_XFER_GO;
  endproperty
  a_apply_only_xfer: assert property (p_apply_only_xfer) else $error("apply w/o xfer");
  property p_no_drive_on_write;
    @(posedge mclk_i) disable iff (rst_i) (st_q == ACSP_DATA && !rd_q) |-> !sdio_oe_o;
  endproperty
  a_no_drive_on_write: assert property (p_no_drive_on_write) else $error("drive on write");
  property p_oe_after_fall;
    @(posedge mclk_i) disable iff (rst_i) $rose(sdio_oe_o) |-> $past(sclk_fall);
  endproperty
  a_oe_after_fall: assert property (p_oe_after_fall) else $error("oe not after fall");
  property p_mid_byte_abort;
    @(posedge mclk_i) disable iff (rst_i)
      (sel_rise && cnt_q != 5'd0 && !strap_q) |=> st_q == ACSP_IDLE && cnt_q == 5'd0;
  endproperty
  a_mid_byte_abort: assert property (p_mid_byte_abort) else $error("no abort");
  property p_strap_holds;
    @(posedge mclk_i) disable iff (rst_i) strap_q |=> strap_q && st_q == ACSP_IDLE;
  endproperty
  a_strap_holds: assert property (p_strap_holds) else $error("strap lost");
  property p_ignore_when_high;
    @(posedge mclk_i) disable iff (rst_i) (sel_s && !sel_rise) |=> !reg_wr_o;
  endproperty
  a_ignore_when_high: assert property (p_ignore_when_high) else $error("write w/ sel high");
  property p_stream_stays;
    @(posedge mclk_i) disable iff (rst_i)
      (st_q == ACSP_DATA && bytes_q == `ACSP_CNT_STREAM && !sel_rise) |=> st_q == ACSP_DATA;
  endproperty
  a_stream_stays: assert property (p_stream_stays) else $error("stream left");
  property p_addr_step;
    @(posedge mclk_i) disable iff (rst_i)
      (st_q == ACSP_DATA && sclk_rise && !sel_s && cnt_q == 5'd7)
        |=> addr_q == $past(addr_q) + 13'h0_001;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("addr not stepped");
  c_write: cover property (@(posedge mclk_i) disable iff (rst_i) reg_wr_o);
  c_read:  cover property (@(posedge mclk_i) disable iff (rst_i) $fell(sdio_oe_o));
  c_apply: cover property (@(posedge mclk_i) disable iff (rst_i) reg_apply_o);
endmodule // acsp_port

// file: verif/acsp_ctrl.sv
/*
  Serial controller model for the configuration port: clock, select and data.
  Assumes the device answers within 4 mclk of a clock fall; data line has a pull-down.
*/
module acsp_ctrl (
  input  wire logic mclk_i,
  input  wire logic dev_oe_i,
  input  wire logic dev_bit_i,
  output logic      sclk_o,
  output logic      sel_n_o,
  output logic      sdio_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv;
  logic bit_q;
  // released line falls to the pull-down, never keeps the last bit
  assign sdio_o = dev_oe_i ? dev_bit_i : (drv ? bit_q : 1'b0);
  initial begin
    sclk_o = 0; sel_n_o = 0; drv = 0; bit_q = 0;
  end
  task automatic half();
    repeat (4) @(negedge mclk_i);
  endtask
  // bit set while clock is low, held through the high phase
  task automatic clk(input logic b, input logic d, output logic s);
    drv = d; bit_q = b; half();
    sclk_o = 1; s = sdio_o; half();
    sclk_o = 0;
  endtask
  task automatic xfer(input logic [15:0] ins, input int n, input logic lsb, input int cut,
                      input logic stall, input logic [31:0] wd, output logic [31:0] rd);
    logic s;
    int   k;
    rd = 0;
    sel_n_o = 0; half();
    for (int i = 15; i >= 0; i--) clk(ins[i], 1'b1, s);
    for (int b = 0; b < n; b++) begin
      if (stall && b > 0) begin
        sel_n_o = 1; half(); half(); sel_n_o = 0; half();
      end
      for (int i = 0; i < 8; i++) begin
        if (b == 0 && i == cut) begin
          drv = 0; sel_n_o = 1; half(); half();
          return;
        end
        k = lsb ? 8 * b + i : 8 * b + 7 - i;
        clk(wd[k], !ins[15], s);
        rd[k] = s;
      end
    end
    half(); drv = 0; sel_n_o = 1; half(); half();
  endtask
endmodule // acsp_ctrl

// file: verif/acsp_port_tb.sv
/*
  Self-checking bench of the configuration serial port with a byte register space.
  Assumes acsp_ctrl models the serial controller.
*/
module acsp_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk_i, rst_i, sclk, seln, sdio, d_bit, d_oe, wr, apply, lsb, strap, tp, rs;
  logic [12:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  mem [0:255];
  logic [31:0] rd;
  int          fails, checked, applies, writes;
  acsp_ctrl u_ctrl (.mclk_i(mclk_i), .dev_oe_i(d_oe), .dev_bit_i(d_bit), .sclk_o(sclk),
                    .sel_n_o(seln), .sdio_o(sdio));
  acsp_port u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .sclk_i(sclk), .select_low_n_i(seln),
    .sdio_i(sdio), .sdio_o(d_bit), .sdio_oe_o(d_oe), .reg_rdata_i(mem[addr[7:0]]),
    .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_apply_o(apply),
    .lsb_first_o(lsb), .strap_mode_o(strap), .test_pattern_strap_o(tp),
    .reduced_swing_strap_o(rs));
  initial begin
    mclk_i = 0;
    forever #50 mclk_i = ~mclk_i;
  end
  // written address is one behind, the port has already stepped
  always @(posedge mclk_i) if (wr === 1'b1) begin
    mem[addr[7:0] - 8'h01] <= wdata;
    writes <= writes + 1;
    if (apply === 1'b1) applies <= applies + 1;
  end
  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_write();
    u_ctrl.xfer({3'b010, 13'h0010}, 3, 0, -1, 1, 32'h00C3_5AA5, rd);
    chk({8'h00, mem[8'h12], mem[8'h11], mem[8'h10]}, 32'h00C3_5AA5);
    chk(applies, 0);
  endtask
  task automatic t_apply();
    u_ctrl.xfer({3'b000, 13'h00FF}, 1, 0, -1, 0, 32'h0000_0001, rd);
    chk(applies, 1);
  endtask
  task automatic t_read();
    mem[8'h20] = 8'h96;
    mem[8'h21] = 8'h3C;
    u_ctrl.xfer({3'b101, 13'h0020}, 2, 0, -1, 0, 32'h0000_0000, rd);
    chk(rd, 32'h0000_3C96);
    chk({31'h0000_0000, d_oe}, 0);
  endtask
  task automatic t_abort();
    u_ctrl.xfer({3'b000, 13'h0040}, 1, 0, 5, 0, 32'h0000_00EE, rd);
    chk({24'h0000_00, mem[8'h40]}, 0);
    u_ctrl.xfer({3'b000, 13'h0040}, 1, 0, -1, 0, 32'h0000_0077, rd);
    chk({24'h0000_00, mem[8'h40]}, 32'h0000_0077);
  endtask
  task automatic t_stream();
    u_ctrl.xfer({3'b011, 13'h0030}, 4, 0, -1, 0, 32'h4433_2211, rd);
    chk({mem[8'h33], mem[8'h32], mem[8'h31], mem[8'h30]}, 32'h4433_2211);
  endtask
  task automatic t_lsb();
    u_ctrl.xfer({3'b000, 13'h0000}, 1, 0, -1, 0, 32'h0000_0040, rd);
    chk({31'h0000_0000, lsb}, 1);
    u_ctrl.xfer({3'b000, 13'h0050}, 1, 1, -1, 0, 32'h0000_0012, rd);
    chk({24'h0000_00, mem[8'h50]}, 32'h0000_0012);
  endtask
  task automatic t_ignore();
    int  w;
    logic s;
    w = writes;
    u_ctrl.sel_n_o = 1;
    for (int i = 0; i < 24; i++) u_ctrl.clk(1'b0, 1'b1, s);
    chk(writes, w);
  endtask
  task automatic t_strap();
    @(negedge mclk_i);
    rst_i = 1; u_ctrl.sel_n_o = 1; u_ctrl.sclk_o = 1; u_ctrl.drv = 0;
    repeat (6) @(negedge mclk_i);
    rst_i = 0;
    repeat (5) @(negedge mclk_i);
    chk({29'h0000_0000, strap, tp, rs}, 32'h0000_0006);
  endtask
  initial begin
    rst_i = 1;
    fails = 0; checked = 0; applies = 0; writes = 0;
    for (int i = 0; i < 256; i++) mem[i] = 8'h00;
    repeat (6) @(negedge mclk_i);
    rst_i = 0;
    repeat (4) @(negedge mclk_i);
    t_write();
    t_apply();
    t_read();
    t_abort();
    t_stream();
    t_lsb();
    t_ignore();
    t_strap();
    give_verdict();
  end
  // eight frames of some 18 to 40 us each, about 225 us in all
  initial begin
    #2_000_000;
    fails++;
    give_verdict();
  end
endmodule // acsp_port_tb
